// ---- verilog/aps_pin_port.sv ----
// module: four user pins with control register on wishbone and secondary serial takeover
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
module aps_pin_port import aps_pkg::*; #(
    parameter int unsigned WORD_W = SERIAL_WORD_W,
    parameter int unsigned HALF_DIV = SERIAL_HALF_DIV,
    parameter int unsigned PERIOD = FRAME_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [WB_ADR_W-1:0] I_WB_ADR,
    input wire logic [WB_SEL_W-1:0] I_WB_SEL,
    input wire logic [WB_DAT_W-1:0] I_WB_DAT,
    output logic [WB_DAT_W-1:0] O_WB_DAT,
    output logic O_WB_ACK,
    input wire logic [WORD_W-1:0] I_ECG_WORD,
    input wire logic I_ECG_VALID,
    input wire logic I_ECG_LAST,
    output logic O_ECG_READY,
    input wire logic [NUM_PINS-1:0] I_USER_PIN_IN,
    output logic [NUM_PINS-1:0] O_USER_PIN_OUT,
    output logic [NUM_PINS-1:0] O_USER_PIN_OE_N
);

    logic [REG_W-1:0] ctrl_r, ctrl_nxt;
    logic [NUM_PINS-1:0] in_r, in_nxt;
    logic ack_r, ack_nxt;
    logic [WB_DAT_W-1:0] dat_r, dat_nxt;
    logic [NUM_PINS-1:0] pin_out_r, pin_out_nxt;
    logic [NUM_PINS-1:0] pin_oe_n_r, pin_oe_n_nxt;
    logic [NUM_PINS-1:0] pin_sync;
    aps_serial_type serial;
    logic hit;
    logic addr_match;
    logic serial_on;

    function automatic aps_pin_mode_type pin_mode(input logic [REG_W-1:0] ctrl,
                                                  input int unsigned pin);
        pin_mode = aps_pin_mode_type'(ctrl[pin*PIN_FIELD_STRIDE+STATE_OFS +: 2]);
    endfunction : pin_mode

    function automatic logic pin_out_value(input logic [REG_W-1:0] ctrl,
                                           input int unsigned pin);
        pin_out_value = ctrl[pin*PIN_FIELD_STRIDE+OUT_OFS];
    endfunction : pin_out_value

    function automatic aps_drive_type pin_drive(input aps_pin_mode_type mode, input logic value);
        aps_drive_type d;
        d = '{out: 1'b0, oe_n: 1'b1};
        case (mode)
            PIN_OUTPUT: begin
                d = '{out: value, oe_n: 1'b0};
            end
            PIN_OPEN_DRAIN: begin
                d = '{out: 1'b0, oe_n: value};
            end
            default: begin
                d = '{out: 1'b0, oe_n: 1'b1};
            end
        endcase
        pin_drive = d;
    endfunction : pin_drive

    function automatic logic [WB_DAT_W-1:0] readback(input logic [REG_W-1:0] ctrl,
                                                      input logic [NUM_PINS-1:0] ins);
        logic [REG_W-1:0] v;
        v = ctrl & PIN_CONTROL_WMASK;
        for (int p = 0; p < NUM_PINS; p++) begin
            v[p*PIN_FIELD_STRIDE+IN_OFS] = ins[p];
        end
        readback = {{(WB_DAT_W-REG_W){1'b0}}, v};
    endfunction : readback

    aps_sync #(
        .WIDTH(NUM_PINS)
    ) u_sync (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_async(I_USER_PIN_IN),
        .o_sync(pin_sync)
    );

    assign serial_on = ctrl_r[ENABLE_BIT];

    aps_serial_tx #(
        .WORD_W(WORD_W),
        .HALF_DIV(HALF_DIV),
        .PERIOD(PERIOD)
    ) u_serial (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_enable(serial_on),
        .i_word_framing(ctrl_r[FRAMING_BIT]),
        .i_word(I_ECG_WORD),
        .i_valid(I_ECG_VALID),
        .i_last(I_ECG_LAST),
        .o_ready(O_ECG_READY),
        .o_link(serial)
    );

    assign hit = I_WB_CYC && I_WB_STB && !ack_r;
    assign addr_match = (I_WB_ADR[WB_ADR_W-1:2] == PIN_CONTROL_IDX);

    // bus slave: one wait state, then ack for one cycle
    always_comb begin
        ack_nxt = hit;
        dat_nxt = dat_r;
        ctrl_nxt = ctrl_r;
        if (hit && !I_WB_WE) begin
            dat_nxt = addr_match ? readback(ctrl_r, in_r) : WB_UNMAPPED_DATA;
        end
        if (hit && I_WB_WE && addr_match) begin
            for (int b = 0; b < REG_BYTES; b++) begin
                if (I_WB_SEL[b]) begin
                    // read-only and reserved bits never store
                    ctrl_nxt[b*8 +: 8] = I_WB_DAT[b*8 +: 8] & PIN_CONTROL_WMASK[b*8 +: 8];
                end
            end
        end
    end

    // pin drive and input capture
    always_comb begin
        aps_drive_type d;
        logic taken;
        d = '{out: 1'b0, oe_n: 1'b1};
        taken = 1'b0;
        pin_out_nxt = pin_out_r;
        pin_oe_n_nxt = pin_oe_n_r;
        in_nxt = in_r;
        for (int p = 0; p < NUM_PINS; p++) begin
            taken = serial_on && (p < NUM_SERIAL_PINS);
            d = pin_drive(pin_mode(ctrl_r, p), pin_out_value(ctrl_r, p));
            if (taken) begin
                // serial output overrides the pin's own state and output bits
                d.oe_n = 1'b0;
                if (p == PIN_CS) begin
                    d.out = serial.cs_n;
                end else if (p == PIN_SCLK) begin
                    d.out = serial.sclk;
                end else begin
                    d.out = serial.data;
                end
            end
            pin_out_nxt[p] = d.out;
            pin_oe_n_nxt[p] = d.oe_n;
            // input bit follows the pin only while the pin is an input
            if (!taken && (pin_mode(ctrl_r, p) == PIN_INPUT)) begin
                in_nxt[p] = pin_sync[p];
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ctrl_r <= PIN_CONTROL_RESET;
            in_r <= '0;
            ack_r <= 1'b0;
            dat_r <= WB_UNMAPPED_DATA;
            pin_out_r <= '0;
            pin_oe_n_r <= '1;
        end else begin
            ctrl_r <= ctrl_nxt;
            in_r <= in_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_n_r <= pin_oe_n_nxt;
        end
    end

    assign O_WB_ACK = ack_r;
    assign O_WB_DAT = dat_r;
    assign O_USER_PIN_OUT = pin_out_r;
    assign O_USER_PIN_OE_N = pin_oe_n_r;

endmodule : aps_pin_port

// ---- verilog/aps_pkg.sv ----
// package: register map, field layout, timing constants and carrier types of the pin port
package aps_pkg;

    localparam int unsigned SYS_CLK_HZ = 40_000_000;
    localparam int unsigned SECONDARY_RATE_HZ = 128_000;
    // frame period in system clocks, rounded down
    localparam int unsigned FRAME_CYCLES = SYS_CLK_HZ / SECONDARY_RATE_HZ;
    localparam int unsigned SERIAL_HALF_DIV = 2;
    localparam int unsigned SERIAL_WORD_W = 24;

    localparam int unsigned NUM_PINS = 4;
    localparam int unsigned NUM_SERIAL_PINS = 3;
    localparam int unsigned REG_W = 24;
    localparam int unsigned WB_ADR_W = 8;
    localparam int unsigned WB_DAT_W = 32;
    localparam int unsigned WB_SEL_W = 4;
    localparam int unsigned REG_BYTES = 3;

    // register index; byte address is four times the index
    localparam logic [5:0] PIN_CONTROL_IDX = 6'h06;
    localparam logic [23:0] PIN_CONTROL_RESET = 24'h00_0000;
    // stored bits: 18, 16, and per pin the state field and output bit
    localparam logic [23:0] PIN_CONTROL_WMASK = 24'h05_eeee;
    localparam logic [31:0] WB_UNMAPPED_DATA = 32'h0000_0000;

    localparam int unsigned ENABLE_BIT = 16;
    localparam int unsigned FRAMING_BIT = 18;
    localparam int unsigned PIN_FIELD_STRIDE = 4;
    localparam int unsigned STATE_OFS = 2;
    localparam int unsigned OUT_OFS = 1;
    localparam int unsigned IN_OFS = 0;

    // pins taken by the secondary serial output
    localparam int unsigned PIN_CS = 0;
    localparam int unsigned PIN_SCLK = 1;
    localparam int unsigned PIN_DATA = 2;

    typedef enum logic [1:0] {
        PIN_HIGHZ = 2'h0,
        PIN_INPUT = 2'h1,
        PIN_OUTPUT = 2'h2,
        PIN_OPEN_DRAIN = 2'h3
    } aps_pin_mode_type;

    typedef struct packed {
        logic out;
        logic oe_n;
    } aps_drive_type;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic data;
    } aps_serial_type;

endpackage : aps_pkg

// ---- verilog/aps_sync.sv ----
// module: two-flop synchroniser for the pin input levels
`timescale 1ns/100ps
module aps_sync import aps_pkg::*; #(
    parameter int unsigned WIDTH = NUM_PINS
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule : aps_sync

// ---- verilog/aps_serial_tx.sv ----
// module: secondary serial output that streams sample words at the frame rate
`timescale 1ns/100ps
module aps_serial_tx import aps_pkg::*; #(
    parameter int unsigned WORD_W = SERIAL_WORD_W,
    parameter int unsigned HALF_DIV = SERIAL_HALF_DIV,
    parameter int unsigned PERIOD = FRAME_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_word_framing,
    input wire logic [WORD_W-1:0] i_word,
    input wire logic i_valid,
    input wire logic i_last,
    output logic o_ready,
    output aps_serial_type o_link
);

    typedef enum {ST_IDLE, ST_SHIFT, ST_GAP} aps_tx_state_type;

    aps_tx_state_type state_r, state_nxt;
    logic [15:0] frame_cnt_r, frame_cnt_nxt;
    logic [7:0] div_r, div_nxt;
    logic [7:0] bit_cnt_r, bit_cnt_nxt;
    logic [WORD_W-1:0] shift_r, shift_nxt;
    logic last_r, last_nxt;
    aps_serial_type link_r, link_nxt;
    logic tick;
    logic div_wrap;
    logic take;

    assign tick = (frame_cnt_r == 16'(PERIOD - 1));
    assign div_wrap = (div_r == 8'(HALF_DIV - 1));
    // a word is taken at a frame tick when idle, or after the gap between words
    assign o_ready = i_enable && (((state_r == ST_IDLE) && tick) || ((state_r == ST_GAP) && div_wrap));
    assign take = o_ready && i_valid;
    assign o_link = link_r;

    always_comb begin
        state_nxt = state_r;
        frame_cnt_nxt = tick ? 16'h0000 : frame_cnt_r + 16'h0001;
        div_nxt = div_wrap ? 8'h00 : div_r + 8'h01;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        last_nxt = last_r;
        link_nxt = link_r;
        if (!i_enable) begin
            state_nxt = ST_IDLE;
            frame_cnt_nxt = 16'h0000;
            div_nxt = 8'h00;
            link_nxt = '{cs_n: 1'b1, sclk: 1'b0, data: 1'b0};
        end else begin
            case (state_r)
                ST_IDLE: begin
                    div_nxt = 8'h00;
                end
                ST_SHIFT: begin
                    if (div_wrap) begin
                        link_nxt.sclk = ~link_r.sclk;
                        // data moves on the falling edge, the reader samples on the rising
                        if (link_r.sclk) begin
                            if (bit_cnt_r == 8'h00) begin
                                state_nxt = last_r ? ST_IDLE : ST_GAP;
                                link_nxt.cs_n = last_r | i_word_framing;
                            end else begin
                                bit_cnt_nxt = bit_cnt_r - 8'h01;
                                shift_nxt = {shift_r[WORD_W-2:0], 1'b0};
                                link_nxt.data = shift_r[WORD_W-2];
                            end
                        end
                    end
                end
                ST_GAP: begin
                    // frame framing keeps select low while the next word is awaited
                    if (div_wrap && !i_valid) begin
                        div_nxt = div_r;
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
            if (take) begin
                state_nxt = ST_SHIFT;
                div_nxt = 8'h00;
                shift_nxt = i_word;
                last_nxt = i_last;
                bit_cnt_nxt = 8'(WORD_W - 1);
                link_nxt = '{cs_n: 1'b0, sclk: 1'b0, data: i_word[WORD_W-1]};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= ST_IDLE;
            frame_cnt_r <= 16'h0000;
            div_r <= 8'h00;
            bit_cnt_r <= 8'h00;
            shift_r <= '0;
            last_r <= 1'b0;
            link_r <= '{cs_n: 1'b1, sclk: 1'b0, data: 1'b0};
        end else begin
            state_r <= state_nxt;
            frame_cnt_r <= frame_cnt_nxt;
            div_r <= div_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            last_r <= last_nxt;
            link_r <= link_nxt;
        end
    end

endmodule : aps_serial_tx

// ---- tb/aps_pin_port_sva.sv ----
// checker: bus, pin drive and serial timing properties of the pin port
`timescale 1ns/100ps
module aps_pin_port_sva import aps_pkg::*; #(
    parameter int unsigned WORD_W = SERIAL_WORD_W
) (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [WB_ADR_W-1:0] I_WB_ADR,
    input wire logic [WB_SEL_W-1:0] I_WB_SEL,
    input wire logic [WB_DAT_W-1:0] I_WB_DAT,
    input wire logic [WB_DAT_W-1:0] O_WB_DAT,
    input wire logic O_WB_ACK,
    input wire logic [WORD_W-1:0] I_ECG_WORD,
    input wire logic I_ECG_VALID,
    input wire logic I_ECG_LAST,
    input wire logic O_ECG_READY,
    input wire logic [NUM_PINS-1:0] I_USER_PIN_IN,
    input wire logic [NUM_PINS-1:0] O_USER_PIN_OUT,
    input wire logic [NUM_PINS-1:0] O_USER_PIN_OE_N
);
    logic [23:0] shd_r;
    logic [23:0] shd_nxt;
    logic [23:0] pin_r;
    logic [23:0] lane;
    logic [3:0] exp_oe_n;
    logic [3:0] drv;
    logic hit;
    // shadow copy of the register, and a copy delayed to the pin update edge
    always_comb begin
        lane = {{8{I_WB_SEL[2]}}, {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}} & PIN_CONTROL_WMASK;
        hit = I_WB_ADR[7:2] == PIN_CONTROL_IDX;
        shd_nxt = shd_r;
        if (I_WB_CYC && I_WB_STB && !O_WB_ACK && I_WB_WE && hit) begin
            shd_nxt = (shd_r & ~lane) | (I_WB_DAT[23:0] & lane);
        end
        for (int i = 0; i < 4; i++) begin
            exp_oe_n[i] = !(pin_r[4*i+3 -: 2] == 2'h2 || (pin_r[4*i+3 -: 2] == 2'h3 && !pin_r[4*i+1]));
            drv[i] = !exp_oe_n[i] && !(pin_r[ENABLE_BIT] && i < 3);
            if (pin_r[ENABLE_BIT] && i < 3) begin
                exp_oe_n[i] = 1'b0;
            end
        end
    end
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            shd_r <= 24'h00_0000;
            pin_r <= 24'h00_0000;
        end else begin
            shd_r <= shd_nxt;
            pin_r <= shd_r;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    AST_ACK_LAT: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
        else $error("ack missing one cycle after request");
    AST_ACK_ONE: assert property (O_WB_ACK |=> !O_WB_ACK)
        else $error("ack longer than one cycle");
    AST_RD_RSVD: assert property (O_WB_ACK |-> O_WB_DAT[31:24] == 8'h00 && O_WB_DAT[23:19] == 5'h00 && !O_WB_DAT[17])
        else $error("reserved read bits not zero");
    AST_RD_VALUE: assert property (O_WB_ACK && $past(!I_WB_WE && hit) |-> (O_WB_DAT[23:0] & PIN_CONTROL_WMASK) == shd_r)
        else $error("stored bits read back wrong");
    AST_RD_UNMAP: assert property (O_WB_ACK && $past(!I_WB_WE && !hit) |-> O_WB_DAT == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_OE_MAP: assert property (O_USER_PIN_OE_N == exp_oe_n)
        else $error("pin enables disagree with mode");
    AST_OUT_MAP: assert property ((O_USER_PIN_OUT & drv) == ({pin_r[13], pin_r[9], pin_r[5], pin_r[1]} & drv))
        else $error("driven pin level disagrees with output bit");
    AST_READY_EN: assert property (O_ECG_READY |-> shd_r[ENABLE_BIT])
        else $error("ready while serial output disabled");
    AST_SCLK_HIGH: assert property (pin_r[ENABLE_BIT] && $rose(O_USER_PIN_OUT[1]) |=> O_USER_PIN_OUT[1] || !pin_r[ENABLE_BIT])
        else $error("serial clock high for one cycle only");
    AST_DATA_HOLD: assert property (pin_r[ENABLE_BIT] && O_USER_PIN_OUT[1] && $past(O_USER_PIN_OUT[1]) |-> $stable(O_USER_PIN_OUT[2]))
        else $error("serial data changed while clock high");
    cover property (O_WB_ACK && $past(I_WB_WE));
    cover property (pin_r[ENABLE_BIT] && !O_USER_PIN_OUT[0]);
    cover property (O_ECG_READY && I_ECG_VALID);
    cover property (pin_r[FRAMING_BIT] && $rose(O_USER_PIN_OUT[0]));
endmodule : aps_pin_port_sva

bind aps_pin_port aps_pin_port_sva #(.WORD_W(WORD_W)) i_aps_pin_port_sva (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
    .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
    .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_ECG_WORD(I_ECG_WORD),
    .I_ECG_VALID(I_ECG_VALID), .I_ECG_LAST(I_ECG_LAST), .O_ECG_READY(O_ECG_READY),
    .I_USER_PIN_IN(I_USER_PIN_IN), .O_USER_PIN_OUT(O_USER_PIN_OUT),
    .O_USER_PIN_OE_N(O_USER_PIN_OE_N));

// ---- tb/aps_far_model.sv ----
// partner: external reader that collects words from the secondary serial pins
`timescale 1ns/100ps
module aps_far_model import aps_pkg::*; #(
    parameter int unsigned WORD_W = SERIAL_WORD_W
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_data,
    output logic [WORD_W-1:0] o_word,
    output int o_n_word,
    output int o_n_cs
);
    logic [WORD_W-1:0] sh;
    int nb;
    logic sclk_d;
    logic cs_d;
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            {sh, o_word, nb, o_n_word, o_n_cs, sclk_d} <= '0;
            // select idles high, so the first edge after reset is no false rise
            cs_d <= 1'b1;
        end else begin
            sclk_d <= i_sclk;
            cs_d <= i_cs_n;
            if (i_cs_n && !cs_d) o_n_cs <= o_n_cs + 1;
            if (i_cs_n) nb <= 0;
            // sample on the rising serial clock, first bit is the msb
            if (!i_cs_n && i_sclk && !sclk_d) begin
                sh <= {sh[WORD_W-2:0], i_data};
                nb <= (nb == WORD_W - 1) ? 0 : nb + 1;
                if (nb == WORD_W - 1) begin
                    o_word <= {sh[WORD_W-2:0], i_data};
                    o_n_word <= o_n_word + 1;
                end
            end
        end
    end
endmodule : aps_far_model

// ---- tb/aps_pin_port_tb_top.sv ----
// testbench: register, pin and secondary serial checks of the pin port
`timescale 1ns/100ps
module aps_pin_port_tb_top import aps_pkg::*;;
    localparam logic [7:0] RA = 8'h18;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ecg_valid = 1'b0, ecg_last = 1'b0, ecg_ready;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, ext_en = 4'h1, ext_v = 4'h1, pin_out, pin_oe_n, pin_w;
    logic [31:0] wdat = 32'h0000_0000, rdat, rd;
    logic [23:0] ecg_word = 24'h00_0000, f_word;
    int n_mismatch = 0, n_tests = 0, n_clk = 0, f_nw, f_ncs, base;
    // pins released by all parties rest at the pull-up level
    always_comb for (int i = 0; i < 4; i++)
        pin_w[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_v[i] : 1'b1);
    aps_pin_port #(.PERIOD(80)) i_aps_pin_port (.I_CLK(clk), .I_RESET_N(rst_n),
        .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
        .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_ECG_WORD(ecg_word),
        .I_ECG_VALID(ecg_valid), .I_ECG_LAST(ecg_last), .O_ECG_READY(ecg_ready),
        .I_USER_PIN_IN(pin_w), .O_USER_PIN_OUT(pin_out), .O_USER_PIN_OE_N(pin_oe_n));
    aps_far_model i_aps_far_model (.i_clk(clk), .i_reset_n(rst_n), .i_cs_n(pin_w[0]),
        .i_sclk(pin_w[1]), .i_data(pin_w[2]), .o_word(f_word), .o_n_word(f_nw),
        .o_n_cs(f_ncs));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task conclude;
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        n_clk++;
        if (n_clk == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
        do @(posedge clk); while (ack !== 1'b1);
        rd = rdat;
        {cyc, stb} <= 2'b00;
    endtask : wb
    task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 4'hf, 32'h0000_0000);
        chk(what, exp, rd);
    endtask : rdchk
    task pins(input logic [3:0] oe, input logic [3:0] out, input logic [3:0] m);
        @(negedge clk);
        chk("pin_oe_n", 32'(oe), 32'(pin_oe_n));
        chk("pin_out", 32'(out & m), 32'(pin_out & m));
    endtask : pins
    // one frame of two words, then wait for the reader and the select release
    task frame(input logic [23:0] w0, input logic [23:0] w1, input int nw);
        @(posedge clk);
        {ecg_word, ecg_last, ecg_valid} <= {w0, 2'b01};
        for (int k = 0; k < 2; k++) begin
            do @(negedge clk); while (ecg_ready !== 1'b1);
            if (k == 1) chk("serial_first", 32'(w0), 32'(f_word));
            @(posedge clk);
            {ecg_word, ecg_last, ecg_valid} <= {w1, 1'b1, k == 0};
        end
        while (f_nw < nw) @(posedge clk);
        while (pin_w[0] !== 1'b1) @(posedge clk);
        // the reader counts the select rise at this edge; look after it settles
        @(negedge clk);
        chk("serial_word", 32'(w1), 32'(f_word));
    endtask : frame
    initial begin
        logic [3:0] nib;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        pins(4'hf, 4'h0, 4'h0);
        rdchk("reset_value", RA, 32'h0000_0000);
        for (int m = 0; m < 4; m++) for (int v = 0; v < 2; v++) begin
            nib = {m[1:0], v[0], 1'b0};
            wb(1'b1, RA, 4'hf, 32'({4{nib}}));
            pins((m == 2 || (m == 3 && v == 0)) ? 4'h0 : 4'hf, (m == 2 && v == 1) ? 4'hf : 4'h0,
                (m == 2 || (m == 3 && v == 0)) ? 4'hf : 4'h0);
            rdchk("stored", RA, 32'({4{nib}}) | ((m > 0) ? 32'h0000_1111 : 32'h0000_0000));
        end
        wb(1'b1, RA, 4'hf, 32'h0000_bdf5);
        pins(4'b0011, 4'b1000, 4'b1100);
        repeat (4) @(posedge clk);
        rdchk("input_high", RA, 32'h0000_bdf5);
        ext_v <= 4'h0;
        repeat (4) @(posedge clk);
        rdchk("input_low", RA, 32'h0000_bdf4);
        wb(1'b1, RA, 4'b0010, 32'h0000_0000);
        rdchk("byte_lane", RA, 32'h0000_11f4);
        wb(1'b1, 8'h1c, 4'hf, 32'h0005_eeee);
        rdchk("unmapped", 8'h1c, 32'h0000_0000);
        rdchk("after_unmapped", RA, 32'h0000_11f4);
        ext_en <= 4'h0;
        wb(1'b1, RA, 4'hf, 32'h0001_a000);
        pins(4'h0, 4'b1000, 4'b1000);
        base = f_ncs;
        frame(24'ha5_0f3c, 24'h3c_c3a5, 2);
        chk("frame_selects", 32'h1, 32'(f_ncs - base));
        wb(1'b1, RA, 4'hf, 32'h0005_a000);
        base = f_ncs;
        frame(24'h80_0001, 24'h7f_fffe, 4);
        chk("word_selects", 32'h2, 32'(f_ncs - base));
        wb(1'b1, RA, 4'hf, 32'h0000_0000);
        pins(4'hf, 4'h0, 4'h0);
        conclude();
    end
endmodule : aps_pin_port_tb_top
